// File: include/acu_regs.svh
`ifndef ACU_REGS_SVH
`define ACU_REGS_SVH

// Register byte offsets
`define ACU_OFF_SEL      8'h00
`define ACU_OFF_KEY      8'h04
`define ACU_OFF_MASK     8'h08
`define ACU_OFF_MODE     8'h0C
`define ACU_OFF_DELAY    8'h10
`define ACU_OFF_TSCTRL   8'h14
`define ACU_OFF_TS_LO    8'h18
`define ACU_OFF_TS_HI    8'h1C
`define ACU_OFF_STATUS   8'h20

// Field positions in the mode register
`define ACU_MODE_ROLE_BIT 0
`define ACU_MODE_SRC_LSB  4
`define ACU_MODE_EDGE_BIT 8

// Reset values
`define ACU_RST_KEY      32'h0000_0000
`define ACU_RST_MASK     32'h0000_0000
`define ACU_RST_DELAY    32'h0000_0000

// Timing
`define ACU_CLK_PERIOD_NS 10
`define ACU_TS_STEP       (64'(`ACU_CLK_PERIOD_NS))

`endif

// File: include/acu_pkg.sv
package acu_pkg;

    typedef enum logic
    {
        ACU_ROLE_LISTEN,
        ACU_ROLE_ORIGIN
    } acu_role_t;

    typedef enum logic [3:0]
    {
        ACU_SRC_OFF,
        ACU_SRC_ACCEPTED_FRAME_TRIGGER,
        ACU_SRC_REJECTED_FRAME_TRIGGER,
        ACU_SRC_FRAME_BEGIN_EVENT,
        ACU_SRC_EXPOSURE_BEGIN_EVENT,
        ACU_SRC_EXPOSURE_FINISH_EVENT,
        ACU_SRC_FIRST_TIMER_EXPIRY,
        ACU_SRC_FIRST_COUNTER_EXPIRY,
        ACU_SRC_INPUT_LINE_ZERO,
        ACU_SRC_INPUT_LINE_ONE
    } acu_src_t;

    typedef enum logic
    {
        ACU_EDGE_FALLING,
        ACU_EDGE_RISING
    } acu_edge_t;

endpackage : acu_pkg

// File: include/acu_act_if.sv
`timescale 1ns/100ps
interface acu_act_if #(parameter int KEY_W = 32);
    import acu_pkg::*;
    logic [KEY_W-1:0] key;
    logic [KEY_W-1:0] mask;
    acu_role_t        role;
    acu_src_t         src;
    acu_edge_t        edge_sel;
    logic [31:0]      delay;
    modport cfg (output key, mask, role, src, edge_sel, delay);
    modport use_p (input key, mask, role, src, edge_sel, delay);
endinterface : acu_act_if

// File: core/acu_origin.sv
`timescale 1ns/100ps
module acu_origin
    import acu_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    acu_act_if.use_p        cfg,
    input  wire logic [6:0] cam_events,
    input  wire logic [1:0] input_lines,
    output logic            fire_q
);
    logic [1:0] line_q;
    logic [1:0] line_d;
    logic       fire_d;
    logic       lvl;

    always_comb
    begin
        line_d = input_lines;
        lvl    = 1'b0;
        fire_d = 1'b0;
        unique case (cfg.src) // [R7]
            ACU_SRC_OFF:                    fire_d = 1'b0; // [R6]
            ACU_SRC_ACCEPTED_FRAME_TRIGGER: fire_d = cam_events[0];
            ACU_SRC_REJECTED_FRAME_TRIGGER: fire_d = cam_events[1];
            ACU_SRC_FRAME_BEGIN_EVENT:      fire_d = cam_events[2];
            ACU_SRC_EXPOSURE_BEGIN_EVENT:   fire_d = cam_events[3];
            ACU_SRC_EXPOSURE_FINISH_EVENT:  fire_d = cam_events[4];
            ACU_SRC_FIRST_TIMER_EXPIRY:     fire_d = cam_events[5];
            ACU_SRC_FIRST_COUNTER_EXPIRY:   fire_d = cam_events[6];
            ACU_SRC_INPUT_LINE_ZERO,
            ACU_SRC_INPUT_LINE_ONE:
            begin
                lvl = (cfg.src == ACU_SRC_INPUT_LINE_ONE);
                if (cfg.edge_sel == ACU_EDGE_RISING) // [R8]
                    fire_d = input_lines[lvl] & ~line_q[lvl];
                else
                    fire_d = ~input_lines[lvl] & line_q[lvl];
            end
            default:                        fire_d = 1'b0;
        endcase
        if (cfg.role != ACU_ROLE_ORIGIN) // [R5]
            fire_d = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_q <= 2'h0;
            fire_q <= 1'b0;
        end
        else
        begin
            line_q <= line_d;
            fire_q <= fire_d;
        end
    end

endmodule : acu_origin

// File: core/acu_listen.sv
`timescale 1ns/100ps
module acu_listen
    import acu_pkg::*;
#(
    parameter int KEY_W = 32
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    acu_act_if.use_p              cfg,
    input  wire logic [63:0]      ts,
    input  wire logic             rx_valid,
    input  wire logic [KEY_W-1:0] rx_key,
    input  wire logic [KEY_W-1:0] rx_mask,
    input  wire logic             rx_sched,
    input  wire logic [63:0]      rx_time,
    output logic                  pend_q,
    output logic                  pulse_q
);
    logic [63:0] when_q;
    logic [63:0] when_d;
    logic        pend_d;
    logic        pulse_d;
    logic        hit;

    always_comb
    begin
        hit = rx_valid && (cfg.role == ACU_ROLE_LISTEN)
              && (rx_key == cfg.key)          // [R2]
              && |(rx_mask & cfg.mask);       // [R3]
        when_d  = when_q;
        pend_d  = pend_q;
        pulse_d = 1'b0;
        if (pend_q && (ts >= when_q)) // [R14]
        begin
            pulse_d = 1'b1;
            pend_d  = 1'b0;
        end
        if (hit && !rx_sched) // [R4]
            pulse_d = 1'b1;
        else if (hit)
        begin
            pend_d = 1'b1;
            when_d = rx_time;
        end
        if (cfg.role != ACU_ROLE_LISTEN)
            pend_d = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            when_q  <= 64'h0000_0000_0000_0000;
            pend_q  <= 1'b0;
            pulse_q <= 1'b0;
        end
        else
        begin
            when_q  <= when_d;
            pend_q  <= pend_d;
            pulse_q <= pulse_d;
        end
    end

endmodule : acu_listen

// File: core/acu_top.sv
// Functional notes
// [R1] Two action commands are held, and an index register picks which one the settings address.
// [R2] A received message counts only if its key equals the configured group key.
// [R3] A received message counts only if its mask shares a set bit with the configured mask.
// [R4] In listener role a matching packet pulses that action's internal signal.
// [R5] In originator role a chosen camera event sends an action packet, unless one for that action is still waiting to be sent.
// [R6] With the origin selection off, no packet is ever sent for that action.
// [R7] Sources: both triggers, frame begin, exposure begin and end, timer, counter, both lines.
// [R8] A line origin fires on the configured falling or rising edge.
// [R9] A scheduled packet carries the current time plus the launch delay in ns.
// [R10] A launch delay of zero sends an unscheduled, immediate action.
// [R11] Software must pick a delay long enough for the packet to arrive before its time.
// [R12] An action travels as one broadcast packet to every device on the segment.
// [R13] Current time is a 64-bit counter run by the internal clock or the network clock.
// [R14] A listener pulse lasts one cycle, and a scheduled one comes when the time is reached.
`timescale 1ns/100ps
`include "acu_regs.svh"
module acu_top
    import acu_pkg::*;
#(
    parameter int KEY_W = 32
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic [2:0]       s_axi_awprot,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic [2:0]       s_axi_arprot,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic [6:0]       cam_events,
    input  wire logic [1:0]       input_lines,
    input  wire logic [63:0]      ptp_time,
    input  wire logic             rx_valid,
    input  wire logic [KEY_W-1:0] rx_key,
    input  wire logic [KEY_W-1:0] rx_mask,
    input  wire logic             rx_sched,
    input  wire logic [63:0]      rx_time,
    output logic                  tx_valid,
    input  wire logic             tx_ready,
    output logic [KEY_W-1:0]      tx_key,
    output logic [KEY_W-1:0]      tx_mask,
    output logic                  tx_sched,
    output logic [63:0]           tx_time,
    output logic [1:0]            action_pulse
);
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    if (KEY_W < 1 || KEY_W > 32)
    begin : g_chk
        $error("acu_top: KEY_W must lie in 1..32");
    end

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction : merge_strb

    function automatic logic known_addr(input logic [7:0] a);
        return a == `ACU_OFF_SEL || a == `ACU_OFF_KEY || a == `ACU_OFF_MASK
            || a == `ACU_OFF_MODE || a == `ACU_OFF_DELAY || a == `ACU_OFF_TSCTRL
            || a == `ACU_OFF_TS_LO || a == `ACU_OFF_TS_HI || a == `ACU_OFF_STATUS;
    endfunction : known_addr

    // Configuration, one set per action for key, mask, mode and delay
    logic             sel_q, sel_d;
    logic [31:0]      key_q   [2];
    logic [31:0]      key_d   [2];
    logic [31:0]      mask_q  [2];
    logic [31:0]      mask_d  [2];
    logic [8:0]       mode_q  [2];
    logic [8:0]       mode_d  [2];
    logic [31:0]      delay_q [2];
    logic [31:0]      delay_d [2];
    logic             ptp_sel_q, ptp_sel_d;
    logic [63:0]      ts_q, ts_d;

    // Bus slave state
    logic             awready_q, awready_d, wready_q, wready_d;
    logic             aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0]       waddr_q, waddr_d;
    logic [31:0]      wdata_q, wdata_d;
    logic [3:0]       wstrb_q, wstrb_d;
    logic             bvalid_q, bvalid_d;
    logic [1:0]       bresp_q, bresp_d;
    logic             arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0]      rdata_q, rdata_d;
    logic [1:0]       rresp_q, rresp_d;
    logic             do_write;
    logic [31:0]      cur_v;

    // Origin side
    logic [1:0]       fire;
    logic [1:0]       req_q, req_d;
    logic [63:0]      req_time_q [2];
    logic [63:0]      req_time_d [2];
    logic [1:0]       req_sched_q, req_sched_d;
    logic             tx_valid_q, tx_valid_d, tx_sched_q, tx_sched_d;
    logic [KEY_W-1:0] tx_key_q, tx_key_d, tx_mask_q, tx_mask_d;
    logic [63:0]      tx_time_q, tx_time_d;
    logic             tx_idx_q, tx_idx_d;
    logic             pick;

    // Listener side
    logic [1:0]       pend;
    logic [1:0]       pulse;

    for (genvar i = 0; i < 2; i++)
    begin : g_act
        acu_act_if #(.KEY_W(KEY_W)) act ();
        assign act.key      = key_q[i][KEY_W-1:0];
        assign act.mask     = mask_q[i][KEY_W-1:0];
        assign act.role     = acu_role_t'(mode_q[i][`ACU_MODE_ROLE_BIT]);
        assign act.src      = acu_src_t'(mode_q[i][`ACU_MODE_SRC_LSB +: 4]);
        assign act.edge_sel = acu_edge_t'(mode_q[i][`ACU_MODE_EDGE_BIT]);
        assign act.delay    = delay_q[i];

        acu_origin u_origin (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .cfg         (act.use_p),
            .cam_events  (cam_events),
            .input_lines (input_lines),
            .fire_q      (fire[i])
        );

        acu_listen #(.KEY_W(KEY_W)) u_listen (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .cfg      (act.use_p),
            .ts       (ts_q),
            .rx_valid (rx_valid),
            .rx_key   (rx_key),
            .rx_mask  (rx_mask),
            .rx_sched (rx_sched),
            .rx_time  (rx_time),
            .pend_q   (pend[i]),
            .pulse_q  (pulse[i])
        );
    end

    // Register slave and configuration
    always_comb
    begin
        awready_d = awready_q;
        wready_d  = wready_q;
        aw_got_d  = aw_got_q;
        w_got_d   = w_got_q;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        sel_d     = sel_q;
        key_d     = key_q;
        mask_d    = mask_q;
        mode_d    = mode_q;
        delay_d   = delay_q;
        ptp_sel_d = ptp_sel_q;
        cur_v     = 32'h0000_0000;

        if (s_axi_awvalid && awready_q)
        begin
            awready_d = 1'b0;
            aw_got_d  = 1'b1;
            waddr_d   = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            wready_d = 1'b0;
            w_got_d  = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        do_write = aw_got_q && w_got_q && !bvalid_q;
        if (do_write)
        begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = known_addr(waddr_q) ? RESP_OKAY : RESP_SLVERR;
            unique case (waddr_q)
                `ACU_OFF_SEL:    cur_v = {31'h0000_0000, sel_q};
                `ACU_OFF_KEY:    cur_v = key_q[sel_q];
                `ACU_OFF_MASK:   cur_v = mask_q[sel_q];
                `ACU_OFF_MODE:   cur_v = {23'h00_0000, mode_q[sel_q]};
                `ACU_OFF_DELAY:  cur_v = delay_q[sel_q];
                `ACU_OFF_TSCTRL: cur_v = {31'h0000_0000, ptp_sel_q};
                default:         cur_v = 32'h0000_0000;
            endcase
            cur_v = merge_strb(cur_v, wdata_q, wstrb_q);
            unique case (waddr_q) // [R1]
                `ACU_OFF_SEL:    sel_d = cur_v[0];
                `ACU_OFF_KEY:    key_d[sel_q] = cur_v;
                `ACU_OFF_MASK:   mask_d[sel_q] = cur_v;
                `ACU_OFF_MODE:   mode_d[sel_q] = cur_v[8:0];
                `ACU_OFF_DELAY:  delay_d[sel_q] = cur_v;
                `ACU_OFF_TSCTRL: ptp_sel_d = cur_v[0];
                default:         cur_v = cur_v;
            endcase
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d  = 1'b0;
            awready_d = 1'b1;
            wready_d  = 1'b1;
        end

        if (s_axi_arvalid && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                `ACU_OFF_SEL:    rdata_d = {31'h0000_0000, sel_q};
                `ACU_OFF_KEY:    rdata_d = key_q[sel_q];
                `ACU_OFF_MASK:   rdata_d = mask_q[sel_q];
                `ACU_OFF_MODE:   rdata_d = {23'h00_0000, mode_q[sel_q]};
                `ACU_OFF_DELAY:  rdata_d = delay_q[sel_q];
                `ACU_OFF_TSCTRL: rdata_d = {31'h0000_0000, ptp_sel_q};
                `ACU_OFF_TS_LO:  rdata_d = ts_q[31:0];
                `ACU_OFF_TS_HI:  rdata_d = ts_q[63:32];
                `ACU_OFF_STATUS: rdata_d = {27'h000_0000, tx_valid_q, req_q, pend};
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    // Timestamp and outgoing packets
    always_comb
    begin
        ts_d = ptp_sel_q ? ptp_time : ts_q + `ACU_TS_STEP; // [R13]
        req_d       = req_q;
        req_time_d  = req_time_q;
        req_sched_d = req_sched_q;
        tx_valid_d  = tx_valid_q;
        tx_key_d    = tx_key_q;
        tx_mask_d   = tx_mask_q;
        tx_sched_d  = tx_sched_q;
        tx_time_d   = tx_time_q;
        tx_idx_d    = tx_idx_q;
        pick        = req_q[0] ? 1'b0 : 1'b1;

        if (tx_valid_q && tx_ready)
        begin
            tx_valid_d       = 1'b0;
            req_d[tx_idx_q]  = 1'b0;
        end
        else if (!tx_valid_q && |req_q) // [R12]
        begin
            tx_valid_d = 1'b1;
            tx_idx_d   = pick;
            tx_key_d   = key_q[pick][KEY_W-1:0];
            tx_mask_d  = mask_q[pick][KEY_W-1:0];
            tx_sched_d = req_sched_q[pick];
            tx_time_d  = req_time_q[pick];
        end

        for (int i = 0; i < 2; i++)
        begin
            if (fire[i] && !(req_q[i] && !(tx_valid_q && tx_ready && tx_idx_q == i)))
            begin
                req_d[i]       = 1'b1;
                req_sched_d[i] = (delay_q[i] != 32'h0000_0000); // [R10]
                req_time_d[i]  = ts_q + {32'h0000_0000, delay_q[i]}; // [R9]
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q   <= 1'b0;
            wready_q    <= 1'b0;
            aw_got_q    <= 1'b0;
            w_got_q     <= 1'b0;
            waddr_q     <= 8'h00;
            wdata_q     <= 32'h0000_0000;
            wstrb_q     <= 4'h0;
            bvalid_q    <= 1'b0;
            bresp_q     <= RESP_OKAY;
            arready_q   <= 1'b0;
            rvalid_q    <= 1'b0;
            rdata_q     <= 32'h0000_0000;
            rresp_q     <= RESP_OKAY;
            sel_q       <= 1'b0;
            key_q       <= '{`ACU_RST_KEY, `ACU_RST_KEY};
            mask_q      <= '{`ACU_RST_MASK, `ACU_RST_MASK};
            mode_q      <= '{9'h000, 9'h000};
            delay_q     <= '{`ACU_RST_DELAY, `ACU_RST_DELAY};
            ptp_sel_q   <= 1'b0;
            ts_q        <= 64'h0000_0000_0000_0000;
            req_q       <= 2'h0;
            req_time_q  <= '{64'h0000_0000_0000_0000, 64'h0000_0000_0000_0000};
            req_sched_q <= 2'h0;
            tx_valid_q  <= 1'b0;
            tx_key_q    <= '0;
            tx_mask_q   <= '0;
            tx_sched_q  <= 1'b0;
            tx_time_q   <= 64'h0000_0000_0000_0000;
            tx_idx_q    <= 1'b0;
        end
        else
        begin
            awready_q   <= awready_d | (!aw_got_q && !w_got_q && !bvalid_q && !wready_q
                                        && !awready_q);
            wready_q    <= wready_d | (!aw_got_q && !w_got_q && !bvalid_q && !wready_q
                                       && !awready_q);
            aw_got_q    <= aw_got_d;
            w_got_q     <= w_got_d;
            waddr_q     <= waddr_d;
            wdata_q     <= wdata_d;
            wstrb_q     <= wstrb_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            arready_q   <= arready_d | (!arready_q && !rvalid_q);
            rvalid_q    <= rvalid_d;
            rdata_q     <= rdata_d;
            rresp_q     <= rresp_d;
            sel_q       <= sel_d;
            key_q       <= key_d;
            mask_q      <= mask_d;
            mode_q      <= mode_d;
            delay_q     <= delay_d;
            ptp_sel_q   <= ptp_sel_d;
            ts_q        <= ts_d;
            req_q       <= req_d;
            req_time_q  <= req_time_d;
            req_sched_q <= req_sched_d;
            tx_valid_q  <= tx_valid_d;
            tx_key_q    <= tx_key_d;
            tx_mask_q   <= tx_mask_d;
            tx_sched_q  <= tx_sched_d;
            tx_time_q   <= tx_time_d;
            tx_idx_q    <= tx_idx_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign tx_valid      = tx_valid_q;
    assign tx_key        = tx_key_q;
    assign tx_mask       = tx_mask_q;
    assign tx_sched      = tx_sched_q;
    assign tx_time       = tx_time_q;
    assign action_pulse  = pulse; // [R14]

endmodule : acu_top

// File: sim/acu_top_monitor.sv
`timescale 1ns/100ps
module acu_top_monitor
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [63:0] tx_time,
    input wire logic [1:0]  action_pulse
);
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_pulse_zero_once : assert property (action_pulse[0] |=> !action_pulse[0])
        else $error("action 0 pulse too long");
    a_pulse_one_once : assert property (action_pulse[1] |=> !action_pulse[1])
        else $error("action 1 pulse too long");
    a_packet_hold : assert property
        (tx_valid && !tx_ready |=> tx_valid && $stable(tx_time))
        else $error("packet changed before taken");
    a_read_answer : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer : assert property
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_aw_taken : assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high");
    a_ar_taken : assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("arready stayed high");
    a_reset_quiet : assert property
        (disable iff (1'b0) !aresetn |=> !tx_valid && action_pulse == 2'b00)
        else $error("output active after reset");
endmodule : acu_top_monitor

bind acu_top acu_top_monitor u_mon
(
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .tx_valid, .tx_ready,
    .tx_time, .action_pulse
);

// File: sim/acu_net_model.sv
`timescale 1ns/100ps
module acu_net_model
(
    input  wire logic   aclk,
    input  wire logic   tx_valid,
    output logic        tx_ready,
    output logic        rx_valid,
    output logic [31:0] rx_key,
    output logic [31:0] rx_mask,
    output logic        rx_sched,
    output logic [63:0] rx_time
);
    initial {tx_ready, rx_valid, rx_key, rx_mask, rx_sched, rx_time} = '0;
    // Idle network takes at once, a busy one may stall
    always @(posedge aclk) tx_ready <= !tx_valid || 1'($urandom_range(1));
    // One broadcast for one cycle, then stale payload is inverted
    task automatic send(logic [31:0] k, logic [31:0] m, logic s, logic [63:0] t);
        {rx_valid, rx_key, rx_mask, rx_sched, rx_time} <= {1'b1, k, m, s, t};
        @(posedge aclk);
        {rx_valid, rx_key, rx_mask, rx_sched, rx_time} <= {1'b0, ~k, ~m, ~s, ~t};
        @(posedge aclk);
    endtask : send
endmodule : acu_net_model

// File: sim/action_command_unit_test.sv
`timescale 1ns/100ps
`include "acu_regs.svh"
module action_command_unit_test
    import acu_pkg::*;
;
    logic         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic         s_axi_rready, tx_ready, rx_valid, rx_sched, s_axi_awready, s_axi_wready;
    logic         s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_valid, tx_sched;
    logic [1:0]   s_axi_bresp, s_axi_rresp, action_pulse, input_lines, bq[$], pq[$];
    logic [2:0]   s_axi_awprot, s_axi_arprot;
    logic [3:0]   s_axi_wstrb;
    logic [6:0]   cam_events;
    logic [7:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata, rx_key, rx_mask, tx_key, tx_mask, k0, d;
    logic [63:0]  ptp_time, rx_time, tx_time;
    logic [33:0]  rq[$];
    logic [128:0] tq[$];
    int           mismatches = 0;
    int           samples_checked = 0;

    acu_top dut (.*);
    acu_net_model net (.aclk, .tx_valid, .tx_ready, .rx_valid, .rx_key, .rx_mask, .rx_sched,
        .rx_time);

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(string n, logic [128:0] e, logic [128:0] g);
        samples_checked++;
        if (e !== g)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic finish_test();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] r = 2'b00);
        bq.push_back(r);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask : wr

    task automatic rd(logic [7:0] a, logic [33:0] e);
        rq.push_back(e);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
    endtask : rd

    task automatic drain();
        int n = 0;
        while (tq.size() + pq.size() > 0 && n < 300)
        begin
            @(posedge aclk);
            n++;
        end
        chk("drain", 0, tq.size() + pq.size());
    endtask : drain

    // Oldest note is compared whenever a result shows at the ports
    always @(posedge aclk)
    begin
        if ((s_axi_bvalid & s_axi_bready) === 1'b1)
            chk("bresp", bq.pop_front(), s_axi_bresp);
        if ((s_axi_rvalid & s_axi_rready) === 1'b1)
            chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if ((tx_valid & tx_ready) === 1'b1)
            chk("tx", tq.pop_front(), {tx_sched, tx_key, tx_mask, tx_time});
        if (action_pulse !== 2'b00) chk("pulse", pq.pop_front(), action_pulse);
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        finish_test();
    end

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cam_events, input_lines, ptp_time} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
        aresetn = 1'b0;
        void'($urandom(32'h1564));
        k0 = $urandom;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ACU_OFF_MODE, 34'h0);
        rd(`ACU_OFF_DELAY, 34'h0);
        rd(8'h24, 34'h2_0000_0000);
        wr(8'h24, k0, 2'b10);
        wr(`ACU_OFF_TSCTRL, 32'h0000_0001);
        for (int i = 1; i >= 0; i--)
        begin
            wr(`ACU_OFF_SEL, 32'(i));
            wr(`ACU_OFF_KEY, i ? ~k0 : k0);
            wr(`ACU_OFF_MASK, i ? 32'h0000_00F0 : 32'h0000_000F);
        end
        rd(`ACU_OFF_KEY, {2'b00, k0});
        pq.push_back(2'b01);
        net.send(k0, 32'h0000_0003, 1'b0, 64'h0);
        net.send(k0, 32'h0000_0010, 1'b0, 64'h0);
        pq.push_back(2'b10);
        net.send(~k0, 32'h0000_0030, 1'b0, 64'h0);
        net.send(k0, 32'h0000_0001, 1'b1, 64'h0000_1000);
        rd(`ACU_OFF_STATUS, 34'h0_0000_0001);
        repeat (8) @(posedge aclk);
        pq.push_back(2'b01);
        ptp_time <= 64'h0000_1000;
        drain();
        ptp_time <= {$urandom, $urandom};
        for (int s = 1; s <= 9; s++)
        begin
            d = (s == 4) ? 32'h0 : $urandom;
            wr(`ACU_OFF_DELAY, d);
            wr(`ACU_OFF_MODE, {23'h0, s[0], s[3:0], 4'h1});
            tq.push_back({d != 0, k0, 32'h0000_000F, ptp_time + 64'(d)});
            cam_events <= 7'(1 << (s - 1));
            input_lines <= (s == 8) ? 2'b01 : (s == 9) ? 2'b10 : 2'b00;
            @(posedge aclk);
            cam_events <= 7'h00;
            repeat (4) @(posedge aclk);
            input_lines <= 2'b00;
            drain();
        end
        wr(`ACU_OFF_MODE, 32'h0000_0001);
        cam_events <= 7'h7F;
        @(posedge aclk);
        cam_events <= 7'h00;
        input_lines <= 2'b11;
        repeat (8) @(posedge aclk);
        finish_test();
    end
endmodule : action_command_unit_test
